// *** usdsc_defs.vh ***
// Constants for the serial transceiver data path, status and enables block.
// Assumes a single 250 MHz core clock and a plain register port.
`ifndef USDSC_DEFS_VH
`define USDSC_DEFS_VH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define USDSC_RX_DATA_LOW_ADDR 8'h00
`define USDSC_RX_DATA_HIGH_ADDR 8'h01
`define USDSC_TX_DATA_LOW_ADDR 8'h02
`define USDSC_TX_DATA_HIGH_ADDR 8'h03
`define USDSC_STATUS_ADDR 8'h04
`define USDSC_CONTROL_A_ADDR 8'h05
`define USDSC_CONTROL_B_ADDR 8'h06
`define USDSC_CONTROL_C_ADDR 8'h07
`define USDSC_BAUD_ADDR 8'h08
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define USDSC_CONTROL_A_RST 8'h00
`define USDSC_CONTROL_B_RST 8'h00
`define USDSC_CONTROL_C_RST 8'h03
`define USDSC_BAUD_RST 8'h10
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define USDSC_ST_RXC 7
`define USDSC_ST_TXC 6
`define USDSC_ST_DRE 5
`define USDSC_ST_RXS 4
`define USDSC_ST_ISF 3
`define USDSC_ST_BDF 1
`define USDSC_ST_WFB 0
`define USDSC_CA_RX_COMPLETE_IRQ_EN 7
`define USDSC_CA_TX_COMPLETE_IRQ_EN 6
`define USDSC_CA_TX_EMPTY_IRQ_EN 5
`define USDSC_CA_START_FRAME_IRQ_EN 4
`define USDSC_CA_LOOP 3
`define USDSC_CA_AUTOBAUD_ERROR_IRQ_EN 2
`define USDSC_CB_RXEN 7
`define USDSC_CB_TXEN 6
`define USDSC_CB_SFDEN 4
`define USDSC_CB_STANDBY 3
// ------------------------------------------------------------
// Encodings and timing
// ------------------------------------------------------------
`define USDSC_MODE_NORMAL 2'h0
`define USDSC_MODE_DOUBLE 2'h1
`define USDSC_MODE_GENERIC_AUTOBAUD_MODE 2'h2
`define USDSC_MODE_CONSTRAINED_AUTOBAUD_MODE 2'h3
`define USDSC_SIZE_5 3'h0
`define USDSC_SIZE_6 3'h1
`define USDSC_SIZE_7 3'h2
`define USDSC_SIZE_9L 3'h6
`define USDSC_SIZE_9H 3'h7
`define USDSC_SYNC_CHAR 8'h55
`define USDSC_BREAK_BITS 5'h0B
`define USDSC_BAUD_MIN 8'h04
`define USDSC_BAUD_MAX 8'hF0
`endif

// *** usdsc_rx_fifo.v ***
// Two-entry receive queue holding data, ninth bit and parity flag.
// Assumes write and read strobes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module usdsc_rx_fifo (
   // Clock and reset
   input wire clk_in,
   input wire rst_n_in,
   // Control
   input wire flush_in,
   input wire push_in,
   input wire [9:0] push_data_in,
   input wire pop_in,
   // State
   output wire [9:0] head_out,
   output wire not_empty_out,
   output wire full_out
);
   reg [9:0] mem [0:1];
   reg rd_idx;
   reg [1:0] count;
   wire wr_idx = rd_idx ^ count[0];
   assign head_out = mem[rd_idx];
   assign not_empty_out = (count != 2'h0);
   assign full_out = count[1];
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_idx <= 1'b0;
         count <= 2'h0;
         mem[0] <= 10'h000;
         mem[1] <= 10'h000;
      end else if (flush_in) begin
         rd_idx <= 1'b0;
         count <= 2'h0;
      end else begin
         // Push is dropped when full; the core leaves full_out open, so overflow goes unflagged
         if (push_in && !full_out)
            mem[wr_idx] <= push_data_in;
         if (pop_in && not_empty_out)
            rd_idx <= ~rd_idx;
         case ({push_in && !full_out, pop_in && not_empty_out})
            2'b10: count <= count + 2'h1;
            2'b01: count <= count - 2'h1;
            default: count <= count;
         endcase
      end
   end
endmodule // usdsc_rx_fifo
`default_nettype wire

// *** usdsc_core.v ***
// Serial transceiver: data registers, status flags, irq enables, shifters.
// Assumes a plain register port and an asynchronous receive pin.
`timescale 1ns/100ps
`default_nettype none
`include "usdsc_defs.vh"
module usdsc_core (
   // Clock and reset
   input wire CORE_CLK_IN,
   input wire RST_N_IN,
   // Register port
   input wire [7:0] ADDR_IN,
   input wire [7:0] WDATA_IN,
   input wire WR_IN,
   input wire RD_IN,
   output reg [7:0] RDATA_OUT,
   // Serial lines
   input wire RXD_IN,
   output reg TXD_OUT,
   // Interrupt vectors
   output reg RX_VECTOR_OUT,
   output reg TX_VECTOR_OUT,
   output reg EMPTY_VECTOR_OUT,
   input wire TX_VECTOR_ACK_IN
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function [7:0] size_mask;
      input [2:0] sz;
      begin
         case (sz)
            `USDSC_SIZE_5: size_mask = 8'h1F;
            `USDSC_SIZE_6: size_mask = 8'h3F;
            `USDSC_SIZE_7: size_mask = 8'h7F;
            default: size_mask = 8'hFF;
         endcase
      end
   endfunction
   function [3:0] size_bits;
      input [2:0] sz;
      begin
         case (sz)
            `USDSC_SIZE_5: size_bits = 4'h5;
            `USDSC_SIZE_6: size_bits = 4'h6;
            `USDSC_SIZE_7: size_bits = 4'h7;
            `USDSC_SIZE_9L: size_bits = 4'h9;
            `USDSC_SIZE_9H: size_bits = 4'h9;
            default: size_bits = 4'h8;
         endcase
      end
   endfunction
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg [7:0] control_a;
   reg [7:0] control_b;
   reg [7:0] control_c;
   reg [7:0] baud;
   reg [7:0] tx_data_low;
   reg tx_data_high;
   reg tx_empty_flag;
   reg tx_complete_flag;
   reg rx_start_flag;
   reg sync_field_error_flag;
   reg break_detected_flag;
   reg wait_for_break;
   wire wr_status = WR_IN && (ADDR_IN == `USDSC_STATUS_ADDR);
   wire wr_txl = WR_IN && (ADDR_IN == `USDSC_TX_DATA_LOW_ADDR);
   wire rxen = control_b[`USDSC_CB_RXEN];
   wire txen = control_b[`USDSC_CB_TXEN];
   wire [1:0] rx_mode = control_b[2:1];
   wire [1:0] parity_mode = control_c[5:4];
   wire [2:0] char_size = control_c[2:0];
   wire auto_mode = rx_mode[1];
   wire lin_mode = (rx_mode == `USDSC_MODE_CONSTRAINED_AUTOBAUD_MODE);
   // ------------------------------------------------------------
   // Receive pin sync and loop-back
   // ------------------------------------------------------------
   reg [2:0] rxd_sync;
   reg rxd_pin;
   always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         rxd_sync <= 3'h7;
         rxd_pin <= 1'b1;
      end else begin
         rxd_sync <= {rxd_sync[1:0], RXD_IN};
         // Change accepted only when stages two and three agree
         if (rxd_sync[1] == rxd_sync[2])
            rxd_pin <= rxd_sync[2];
      end
   end
   wire rx_line = control_a[`USDSC_CA_LOOP] ? TXD_OUT : rxd_pin;
   reg rx_line_d;
   // ------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------
   reg [10:0] tx_shift;
   reg [3:0] tx_left;
   reg [7:0] tx_tick;
   reg tx_busy;
   wire tx_load = txen && tx_empty_flag == 1'b0 && !tx_busy;
   wire tx_par = ^(tx_data_low & size_mask(char_size)) ^ parity_mode[0];
   always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         tx_shift <= 11'h7FF;
         tx_left <= 4'h0;
         tx_tick <= 8'h00;
         tx_busy <= 1'b0;
         TXD_OUT <= 1'b1;
      end else if (tx_load) begin
         // Unused upper bits masked off before shifting
         tx_shift <= {tx_par, tx_data_high, tx_data_low & size_mask(char_size)};
         tx_left <= size_bits(char_size) + (parity_mode[1] ? 4'h2 : 4'h1);
         tx_tick <= baud;
         tx_busy <= 1'b1;
         TXD_OUT <= 1'b0;
      end else if (tx_busy) begin
         if (tx_tick != 8'h00) begin
            tx_tick <= tx_tick - 8'h01;
         end else if (tx_left == 4'h0) begin
            tx_busy <= 1'b0;
            TXD_OUT <= 1'b1;
         end else begin
            tx_tick <= baud;
            tx_left <= tx_left - 4'h1;
            // Parity sits right after the data bits; stop bit is the final one
            if (tx_left == 4'h1)
               TXD_OUT <= 1'b1;
            else if (parity_mode[1] && tx_left == 4'h2)
               TXD_OUT <= tx_shift[10];
            else
               TXD_OUT <= tx_shift[0];
            if (!(parity_mode[1] && tx_left == 4'h2))
               tx_shift <= {tx_shift[10], 1'b1, tx_shift[9:1]};
         end
      end
   end
   wire tx_done = tx_busy && tx_tick == 8'h00 && tx_left == 4'h0;
   // ------------------------------------------------------------
   // Receiver state machine
   // ------------------------------------------------------------
   localparam RX_IDLE = 4'b0001;
   localparam RX_DATA = 4'b0010;
   localparam RX_STOP = 4'b0100;
   localparam RX_BRK = 4'b1000;
   reg [3:0] rx_state;
   reg [7:0] rx_tick;
   reg [3:0] rx_cnt;
   reg [9:0] rx_shift;
   reg rx_par_in;
   reg [4:0] brk_bits;
   reg want_sync;
   reg pid_next;
   reg rx_push;
   reg [9:0] rx_word;
   wire sync_err_set;
   wire sync_err_clr = wr_status && WDATA_IN[`USDSC_ST_ISF];
   wire [3:0] rx_nbits = size_bits(char_size);
   wire fall = rx_line_d && !rx_line;
   wire rise = !rx_line_d && rx_line;
   wire [7:0] rx_byte = rx_shift[7:0] & size_mask(char_size);
   wire par_bad = parity_mode[1] && ((^rx_byte) ^ parity_mode[0] ^ rx_par_in);
   wire bad_rate = (baud < `USDSC_BAUD_MIN) || (baud > `USDSC_BAUD_MAX);
   assign sync_err_set = rx_state == RX_STOP && rx_tick == 8'h00 && want_sync &&
      (bad_rate || (lin_mode && rx_byte != `USDSC_SYNC_CHAR));
   always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         rx_state <= RX_IDLE;
         rx_tick <= 8'h00;
         rx_cnt <= 4'h0;
         rx_shift <= 10'h000;
         rx_par_in <= 1'b0;
         brk_bits <= 5'h00;
         want_sync <= 1'b0;
         pid_next <= 1'b0;
         rx_push <= 1'b0;
         rx_word <= 10'h000;
         rx_line_d <= 1'b1;
      end else begin
         rx_line_d <= rx_line;
         rx_push <= 1'b0;
         if (!rxen || sync_err_clr) begin
            rx_state <= RX_IDLE;
            want_sync <= 1'b0;
            pid_next <= 1'b0;
         end else begin
            case (rx_state)
               RX_IDLE: begin
                  if (fall) begin
                     rx_state <= wait_for_break ? RX_BRK : RX_DATA;
                     rx_tick <= {1'b0, baud[7:1]};
                     rx_cnt <= 4'h0;
                     rx_shift <= 10'h000;
                     brk_bits <= 5'h00;
                  end
               end
               RX_BRK: begin
                  // Any width counts once the line returns high
                  if (rise) begin
                     rx_state <= RX_IDLE;
                     want_sync <= 1'b1;
                  end
               end
               RX_DATA: begin
                  if (rx_tick != 8'h00) begin
                     rx_tick <= rx_tick - 8'h01;
                  end else begin
                     rx_tick <= baud;
                     rx_cnt <= rx_cnt + 4'h1;
                     brk_bits <= rx_line ? 5'h00 : brk_bits + 5'h01;
                     if (rx_cnt == 4'h0) begin
                        rx_cnt <= 4'h1;
                     end else if (rx_cnt <= rx_nbits) begin
                        rx_shift[rx_cnt - 4'h1] <= rx_line;
                     end else if (parity_mode[1] && rx_cnt == rx_nbits + 4'h1) begin
                        rx_par_in <= rx_line;
                     end else if (auto_mode && !rx_line && brk_bits != 5'h1F) begin
                        // Line still low past the frame: keep counting break bits
                        rx_cnt <= rx_cnt;
                     end else begin
                        rx_state <= RX_STOP;
                        rx_tick <= 8'h00;
                     end
                  end
               end
               RX_STOP: begin
                  rx_state <= RX_IDLE;
                  if (auto_mode && brk_bits >= `USDSC_BREAK_BITS) begin
                     want_sync <= 1'b1;
                  end else if (want_sync) begin
                     want_sync <= 1'b0;
                     pid_next <= lin_mode && !sync_err_set;
                  end else begin
                     rx_push <= 1'b1;
                     pid_next <= 1'b0;
                     // Constrained mode: ninth bit flags response space
                     if (lin_mode)
                        rx_word <= {!pid_next, par_bad, rx_byte};
                     else
                        rx_word <= {rx_shift[8], par_bad, rx_byte};
                  end
               end
               default: rx_state <= RX_IDLE;
            endcase
         end
      end
   end
   // ------------------------------------------------------------
   // Receive queue
   // ------------------------------------------------------------
   wire [9:0] rx_head;
   wire rx_complete_flag;
   wire low_first = (char_size == `USDSC_SIZE_9L);
   wire rd_low = RD_IN && ADDR_IN == `USDSC_RX_DATA_LOW_ADDR;
   wire rd_high = RD_IN && ADDR_IN == `USDSC_RX_DATA_HIGH_ADDR;
   // Advance on the second byte of the pair so flags match the data
   wire rx_pop = low_first ? rd_high : rd_low;
   usdsc_rx_fifo u_rx_fifo (
      .clk_in(CORE_CLK_IN),
      .rst_n_in(RST_N_IN),
      .flush_in(!rxen),
      .push_in(rx_push),
      .push_data_in({rx_word[9], rx_word[8] & parity_mode[1], rx_word[7:0]}),
      .pop_in(rx_pop),
      .head_out(rx_head),
      .not_empty_out(rx_complete_flag),
      .full_out()
   );
   // ------------------------------------------------------------
   // Status flags and control writes
   // ------------------------------------------------------------
   always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         control_a <= `USDSC_CONTROL_A_RST;
         control_b <= `USDSC_CONTROL_B_RST;
         control_c <= `USDSC_CONTROL_C_RST;
         baud <= `USDSC_BAUD_RST;
         tx_data_low <= 8'h00;
         tx_data_high <= 1'b0;
         tx_empty_flag <= 1'b1;
         tx_complete_flag <= 1'b0;
         rx_start_flag <= 1'b0;
         sync_field_error_flag <= 1'b0;
         break_detected_flag <= 1'b0;
         wait_for_break <= 1'b0;
      end else begin
         if (WR_IN && ADDR_IN == `USDSC_CONTROL_A_ADDR)
            control_a <= WDATA_IN;
         if (WR_IN && ADDR_IN == `USDSC_CONTROL_B_ADDR)
            control_b <= WDATA_IN;
         if (WR_IN && ADDR_IN == `USDSC_CONTROL_C_ADDR)
            control_c <= WDATA_IN;
         if (WR_IN && ADDR_IN == `USDSC_BAUD_ADDR)
            baud <= WDATA_IN;
         if (WR_IN && ADDR_IN == `USDSC_TX_DATA_HIGH_ADDR)
            tx_data_high <= WDATA_IN[0];
         // Writes while not empty are dropped, protecting the pending byte
         if (wr_txl && tx_empty_flag) begin
            tx_data_low <= WDATA_IN;
            tx_empty_flag <= 1'b0;
         end else if (tx_load) begin
            tx_empty_flag <= 1'b1;
         end
         // Set wins over a simultaneous clear
         if (tx_done && tx_empty_flag)
            tx_complete_flag <= 1'b1;
         else if (TX_VECTOR_ACK_IN || (wr_status && WDATA_IN[`USDSC_ST_TXC]))
            tx_complete_flag <= 1'b0;
         if (control_b[`USDSC_CB_SFDEN] && control_b[`USDSC_CB_STANDBY] && fall)
            rx_start_flag <= 1'b1;
         else if ((wr_status && WDATA_IN[`USDSC_ST_RXS]) || !control_b[`USDSC_CB_SFDEN])
            rx_start_flag <= 1'b0;
         if (sync_err_set)
            sync_field_error_flag <= 1'b1;
         else if (sync_err_clr)
            sync_field_error_flag <= 1'b0;
         if (rx_state == RX_STOP && want_sync && auto_mode && !sync_err_set)
            break_detected_flag <= 1'b1;
         else if (rx_push || (wr_status && WDATA_IN[`USDSC_ST_BDF]))
            break_detected_flag <= 1'b0;
         if (wr_status && WDATA_IN[`USDSC_ST_WFB])
            wait_for_break <= 1'b1;
         else if (rx_state == RX_BRK && rise)
            wait_for_break <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // Read mux and interrupt vectors
   // ------------------------------------------------------------
   reg [7:0] next_rdata;
   always @* begin
      next_rdata = 8'h00;
      case (ADDR_IN)
         `USDSC_RX_DATA_LOW_ADDR: next_rdata = rx_head[7:0] & size_mask(char_size);
         `USDSC_RX_DATA_HIGH_ADDR:
            next_rdata = {rx_complete_flag, 5'h00, rx_head[8] & parity_mode[1], rx_head[9]};
         `USDSC_TX_DATA_LOW_ADDR: next_rdata = tx_data_low;
         `USDSC_STATUS_ADDR:
            // Wait-for-break position always reads zero
            next_rdata = {rx_complete_flag, tx_complete_flag, tx_empty_flag,
               rx_start_flag, sync_field_error_flag, 1'b0, break_detected_flag, 1'b0};
         `USDSC_CONTROL_A_ADDR: next_rdata = control_a;
         `USDSC_CONTROL_B_ADDR: next_rdata = control_b;
         `USDSC_CONTROL_C_ADDR: next_rdata = control_c;
         `USDSC_BAUD_ADDR: next_rdata = baud;
         default: next_rdata = 8'h00;
      endcase
   end
   always @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         RDATA_OUT <= 8'h00;
         RX_VECTOR_OUT <= 1'b0;
         TX_VECTOR_OUT <= 1'b0;
         EMPTY_VECTOR_OUT <= 1'b0;
      end else begin
         RDATA_OUT <= RD_IN ? next_rdata : 8'h00;
         // Levels: each request holds while its flag stays set
         RX_VECTOR_OUT <= (rx_complete_flag && control_a[`USDSC_CA_RX_COMPLETE_IRQ_EN]) ||
            (rx_start_flag && control_a[`USDSC_CA_START_FRAME_IRQ_EN]) ||
            (sync_field_error_flag && control_a[`USDSC_CA_AUTOBAUD_ERROR_IRQ_EN]);
         TX_VECTOR_OUT <= tx_complete_flag && control_a[`USDSC_CA_TX_COMPLETE_IRQ_EN];
         EMPTY_VECTOR_OUT <= tx_empty_flag && control_a[`USDSC_CA_TX_EMPTY_IRQ_EN];
      end
   end
endmodule // usdsc_core
`default_nettype wire

// *** usdsc_core_chk.sv ***
// Checker for the serial data, status and enable block.
// Assumes it is bound to usdsc_core and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module usdsc_core_chk (
   // Clock, reset and register port
   input wire logic CORE_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [7:0] RDATA_OUT,
   // Lines and vectors
   input wire logic RXD_IN,
   input wire logic TXD_OUT,
   input wire logic RX_VECTOR_OUT,
   input wire logic TX_VECTOR_OUT,
   input wire logic EMPTY_VECTOR_OUT,
   input wire logic TX_VECTOR_ACK_IN
);
   // Shadows of the control registers, written at the same edge as the design's
   logic [7:0] ctl_a;
   logic [7:0] ctl_b;
   logic [7:0] ctl_c;
   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ctl_a <= 8'h00;
         ctl_b <= 8'h00;
         ctl_c <= 8'h03;
      end else begin
         ctl_a <= (WR_IN && ADDR_IN == 8'h05) ? WDATA_IN : ctl_a;
         ctl_b <= (WR_IN && ADDR_IN == 8'h06) ? WDATA_IN : ctl_b;
         ctl_c <= (WR_IN && ADDR_IN == 8'h07) ? WDATA_IN : ctl_c;
      end
   end
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   sequence st_rd;
      RD_IN && ADDR_IN == 8'h04;
   endsequence
   wfb_reads_zero_a: assert property (st_rd |=> !RDATA_OUT[0])
      else $error("wait-for-break bit read as one");
   no_break_flag_a: assert property (st_rd and ctl_b[2:1] == 2'h0 |=> !RDATA_OUT[1])
      else $error("break flag seen in normal mode");
   no_start_flag_a: assert property (st_rd and !ctl_b[4] |=> !RDATA_OUT[4])
      else $error("start flag seen with detection off");
   parity_error_flag_off_zero_a: assert property (RD_IN && ADDR_IN == 8'h01 && ctl_c[5:4] == 2'h0
      |=> !RDATA_OUT[1]) else $error("parity error with checking off");
   upper_bits_zero_a: assert property (RD_IN && ADDR_IN == 8'h00 && ctl_c[2:0] == 3'h0
      |=> RDATA_OUT[7:5] == 3'h0) else $error("unused receive bits not zero");
   empty_irq_gate_a: assert property (!ctl_a[5] && !$past(ctl_a[5]) |-> !EMPTY_VECTOR_OUT)
      else $error("empty vector without its enable");
   tx_irq_gate_a: assert property (!ctl_a[6] && !$past(ctl_a[6]) |-> !TX_VECTOR_OUT)
      else $error("transmit vector without its enable");
   rx_irq_gate_a: assert property ((ctl_a & 8'h94) == 8'h00 && ($past(ctl_a) & 8'h94) == 8'h00
      |-> !RX_VECTOR_OUT) else $error("receive vector without an enable");
   txc_clear_a: assert property ((WR_IN && ADDR_IN == 8'h04 && WDATA_IN[6]) || TX_VECTOR_ACK_IN
      |-> ##2 !TX_VECTOR_OUT) else $error("transmit vector kept after clear");
   cover property (TX_VECTOR_OUT);
   cover property (RX_VECTOR_OUT && EMPTY_VECTOR_OUT);
   cover property (RD_IN && ADDR_IN == 8'h01 ##1 RDATA_OUT[1]);
endmodule // usdsc_core_chk
bind usdsc_core usdsc_core_chk usdsc_core_chk_i (.CORE_CLK_IN(CORE_CLK_IN),
   .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
   .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .RXD_IN(RXD_IN), .TXD_OUT(TXD_OUT),
   .RX_VECTOR_OUT(RX_VECTOR_OUT), .TX_VECTOR_OUT(TX_VECTOR_OUT),
   .EMPTY_VECTOR_OUT(EMPTY_VECTOR_OUT), .TX_VECTOR_ACK_IN(TX_VECTOR_ACK_IN));
`default_nettype wire

// *** usdsc_remote.sv ***
// Remote serial node: decodes the transmit line and drives the receive line.
// Assumes 8 data bits, one stop bit and BIT_CYC clocks per bit.
`timescale 1ns/100ps
`default_nettype none
module usdsc_remote #(
   parameter int BIT_CYC = 8
) (
   input wire logic clk_in,
   input wire logic txd_in,
   output var logic rxd_out
);
   logic [7:0] got_q[$];
   logic [7:0] sh;
   initial rxd_out = 1'b1;
   // Mid-bit sampling tolerates the receive-side synchroniser delay
   always begin
      @(negedge txd_in);
      repeat (BIT_CYC / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge clk_in);
         sh[i] = txd_in;
      end
      repeat (BIT_CYC) @(posedge clk_in);
      got_q.push_back(sh);
   end
   // Line is driven high for the stop bit and left high
   task automatic send(input logic [7:0] b, input logic par_on, input logic par);
      rxd_out <= 1'b0;
      repeat (BIT_CYC) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
         rxd_out <= b[i];
         repeat (BIT_CYC) @(posedge clk_in);
      end
      if (par_on) begin
         rxd_out <= par;
         repeat (BIT_CYC) @(posedge clk_in);
      end
      rxd_out <= 1'b1;
      repeat (BIT_CYC) @(posedge clk_in);
   endtask
endmodule // usdsc_remote
`default_nettype wire

// *** test_usdsc_core.sv ***
// Self-checking bench for the serial data, status and enable block.
// Assumes a remote node model at 8 clocks per bit (baud register 07).
`timescale 1ns/100ps
`default_nettype none
module test_usdsc_core;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic ack = 1'b0;
   logic [7:0] rdata;
   logic rxd, txd, rx_vec, tx_vec, em_vec;
   logic [7:0] d;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   usdsc_core usdsc_core_i (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
      .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata), .RXD_IN(rxd),
      .TXD_OUT(txd), .RX_VECTOR_OUT(rx_vec), .TX_VECTOR_OUT(tx_vec),
      .EMPTY_VECTOR_OUT(em_vec), .TX_VECTOR_ACK_IN(ack));
   usdsc_remote #(.BIT_CYC(8)) usdsc_remote_i (.clk_in(clk), .txd_in(txd), .rxd_out(rxd));
   always #2 clk = ~clk;
   task automatic give_verdict;
      $display("checked %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard, well above the roughly one thousand cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         give_verdict;
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      @(posedge clk);
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      v = rdata;
      @(posedge clk);
   endtask
   task automatic t_reset;
      bus_rd(8'h04, d);
      chk(d, 8'h20);
      bus_rd(8'h05, d);
      chk(d, 8'h00);
      bus_rd(8'h3F, d);
      chk(d, 8'h00);
   endtask
   task automatic t_tx;
      bus_wr(8'h08, 8'h07);
      bus_wr(8'h06, 8'h40);
      bus_wr(8'h05, 8'h60);
      tick(2);
      chk({7'h0, em_vec}, 8'h01);
      bus_wr(8'h02, 8'hA5);
      tick(4);
      bus_wr(8'h02, 8'h3C);
      bus_wr(8'h02, 8'hFF);
      bus_rd(8'h04, d);
      chk(d, 8'h00);
      chk({7'h0, em_vec}, 8'h00);
      for (int i = 0; i < 400 && usdsc_remote_i.got_q.size() < 2; i++) tick(1);
      tick(20);
      chk(8'(usdsc_remote_i.got_q.size()), 8'h02);
      chk(usdsc_remote_i.got_q[0], 8'hA5);
      chk(usdsc_remote_i.got_q[1], 8'h3C);
      bus_rd(8'h04, d);
      chk(d, 8'h60);
      chk({7'h0, tx_vec}, 8'h01);
      bus_wr(8'h04, 8'h40);
      tick(2);
      chk({7'h0, tx_vec}, 8'h00);
      bus_wr(8'h02, 8'h11);
      tick(120);
      chk({7'h0, tx_vec}, 8'h01);
      ack <= 1'b1;
      tick(1);
      ack <= 1'b0;
      tick(3);
      chk({7'h0, tx_vec}, 8'h00);
   endtask
   task automatic t_rx;
      bus_wr(8'h06, 8'h98);
      bus_wr(8'h05, 8'h90);
      usdsc_remote_i.send(8'h5A, 1'b0, 1'b0);
      usdsc_remote_i.send(8'hC3, 1'b0, 1'b0);
      tick(20);
      bus_rd(8'h04, d);
      chk(d, 8'hB0);
      chk({7'h0, rx_vec}, 8'h01);
      bus_wr(8'h04, 8'h10);
      bus_rd(8'h01, d);
      chk(d, 8'h80);
      bus_rd(8'h00, d);
      chk(d, 8'h5A);
      bus_rd(8'h01, d);
      chk(d, 8'h80);
      bus_rd(8'h00, d);
      chk(d, 8'hC3);
      tick(2);
      bus_rd(8'h04, d);
      chk(d, 8'h20);
      chk({7'h0, rx_vec}, 8'h00);
      usdsc_remote_i.send(8'h77, 1'b0, 1'b0);
      tick(20);
      bus_wr(8'h06, 8'h00);
      bus_rd(8'h04, d);
      chk(d, 8'h20);
   endtask
   task automatic t_par;
      bus_wr(8'h07, 8'h23);
      bus_wr(8'h06, 8'h80);
      usdsc_remote_i.send(8'hF0, 1'b1, 1'b1);
      tick(20);
      bus_rd(8'h01, d);
      chk(d, 8'h82);
      bus_rd(8'h00, d);
      chk(d, 8'hF0);
   endtask
   task automatic t_loop;
      bus_wr(8'h07, 8'h00);
      bus_wr(8'h05, 8'h08);
      bus_wr(8'h06, 8'hC0);
      bus_wr(8'h02, 8'hFF);
      tick(120);
      bus_rd(8'h01, d);
      chk(d, 8'h80);
      bus_rd(8'h00, d);
      chk(d, 8'h1F);
      bus_wr(8'h07, 8'h07);
      bus_wr(8'h03, 8'h01);
      bus_wr(8'h02, 8'h5A);
      tick(120);
      bus_rd(8'h01, d);
      chk(d, 8'h81);
      bus_rd(8'h00, d);
      chk(d, 8'h5A);
      bus_wr(8'h04, 8'h01);
      bus_rd(8'h04, d);
      chk(d & 8'h01, 8'h00);
   endtask
   initial begin
      tick(5);
      rst_n <= 1'b1;
      tick(1);
      t_reset;
      t_tx;
      t_rx;
      t_par;
      t_loop;
      give_verdict;
   end
endmodule // test_usdsc_core
`default_nettype wire
